// file: src/bfl_pkg.sv
// Package: register map, field layouts, reset values and timing counts for the buck fault block
package bfl_pkg;

  // Clock figures
  localparam int CLK_MHZ            = 250;
  localparam int HICCUP_MS          = 20;
  localparam int HICCUP_CYCLES      = HICCUP_MS * 1000 * CLK_MHZ;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_OT_LIMIT  = 8'h04;
  localparam logic [7:0] ADDR_OC_MAX    = 8'h08;
  localparam logic [7:0] ADDR_TEMP      = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_CALIB     = 8'h14;

  // Control register fields
  localparam int CTRL_CC_BIT        = 0;
  localparam int CTRL_AOT_BIT       = 1;
  localparam int CTRL_OTR_LSB       = 2;
  localparam int CTRL_LATCH_CLR_BIT = 4;

  // Reset values and thresholds
  localparam logic [31:0] CTRL_RST     = 32'h0000_0005;
  localparam logic [7:0]  OT_LIMIT_RST = 8'h7d;
  localparam logic [7:0]  OC_MAX_RST   = 8'h08;
  localparam logic [7:0]  OT_HYST      = 8'h19;
  localparam logic [7:0]  TEMP_OFFSET  = 8'h28;
  localparam logic [2:0]  OC_RUN       = 3'h3;
  localparam logic [2:0]  OK_RUN       = 3'h4;
  localparam logic [3:0]  ZC_RUN       = 4'h8;
  localparam logic [1:0]  BELOW_RUN    = 2'h3;

  // Over-temperature response encodings
  typedef enum logic [1:0] {
    OTR_IGNORE  = 2'h0,
    OTR_INHIBIT = 2'h1,
    OTR_LATCH   = 2'h2
  } bfl_otr_t;

  // Duty cap levels: nominal, 1/2, 1/4, 1/8
  typedef enum logic [1:0] {
    CAP_NOM   = 2'h0,
    CAP_HALF  = 2'h1,
    CAP_QUART = 2'h3,
    CAP_EIGHT = 2'h2
  } bfl_cap_t;

  // Light-load mode states
  typedef enum logic [1:0] {
    LL_FORCED_CONTINUOUS_MODE  = 2'h0,
    LL_PULSE = 2'h1,
    LL_DIODE = 2'h3,
    LL_IDLE  = 2'h2
  } bfl_ll_t;

  // Analog comparator inputs, sampled on every clock
  typedef struct packed {
    logic overcurrent_trip;
    logic zero_cross;
    logic current_pos;
    logic vsense_below_ref;
    logic vsense_below_95;
    logic power_input_voltage_above_4v7;
    logic ref_ramping;
    logic tracking;
  } bfl_sense_t;

  // Control register copy
  typedef struct packed {
    logic       cc_mode;
    logic       aot_enable;
    bfl_otr_t   otr;
  } bfl_cfg_t;

endpackage : bfl_pkg

// file: src/bfl_foldback.sv
// Foldback: steps the duty cap down on overcurrent runs, up on clear runs, counts toward hiccup
`timescale 1ns/100ps
`default_nettype none
module bfl_foldback
  import bfl_pkg::*;
#(
  parameter int HICCUP_LEN = HICCUP_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       cyc_en_i,
  input  wire logic       oc_i,
  input  wire logic       cc_mode_i,
  input  wire logic [7:0] oc_max_i,
  input  wire logic [7:0] duty_nom_i,
  output logic      [7:0] duty_o,
  output logic            hiccup_o,
  output bfl_cap_t        cap_o
);

  typedef struct packed {
    bfl_cap_t    cap;
    logic [2:0]  oc_run;
    logic [2:0]  ok_run;
    logic [7:0]  oc_total;
    logic        hiccup;
    logic [31:0] hic_cnt;
    logic [7:0]  duty;
  } bfl_fb_st_t;

  bfl_fb_st_t st_r, st_nxt;

  // Cap value for a level, duty scale 8'hff = full
  function automatic logic [7:0] cap_value(bfl_cap_t c);
    case (c)
      CAP_HALF:  cap_value = 8'h80;
      CAP_QUART: cap_value = 8'h40;
      CAP_EIGHT: cap_value = 8'h20;
      default:   cap_value = 8'hff;
    endcase
  endfunction

  // Next-state logic for the foldback sequence
  always_comb begin
    st_nxt = st_r;
    if (st_r.hiccup) begin
      st_nxt.duty = 8'h00;
      if (st_r.hic_cnt == 32'(HICCUP_LEN - 1)) begin
        st_nxt = '0;                                            // Retry after hiccup [R5]
      end else begin
        st_nxt.hic_cnt = st_r.hic_cnt + 32'h1;
      end
    end else if (cyc_en_i) begin
      if (oc_i) begin
        st_nxt.ok_run   = 3'h0;
        st_nxt.oc_total = st_r.oc_total + 8'h1;
        if (st_r.oc_total + 8'h1 >= oc_max_i) begin
          st_nxt.hiccup  = 1'b1;                                 // Enter hiccup at max count [R3][R5]
          st_nxt.hic_cnt = 32'h0;
        end else if (cc_mode_i && st_r.oc_run + 3'h1 == OC_RUN) begin
          st_nxt.oc_run = 3'h0;
          case (st_r.cap)
            CAP_NOM:   st_nxt.cap = (duty_nom_i > 8'h80) ? CAP_HALF :
                                    (duty_nom_i > 8'h40) ? CAP_QUART :
                                    (duty_nom_i > 8'h20) ? CAP_EIGHT : CAP_NOM; // [R1]
            CAP_HALF:  st_nxt.cap = CAP_QUART;                   // [R2]
            default:   st_nxt.cap = CAP_EIGHT;                   // Quarter steps to 1/8, and 1/8 holds [R2][R3]
          endcase
        end else begin
          st_nxt.oc_run = st_r.oc_run + 3'h1;
        end
      end else begin
        st_nxt.oc_run = 3'h0;
        if (st_r.cap != CAP_NOM && st_r.ok_run + 3'h1 == OK_RUN) begin
          st_nxt.ok_run = 3'h0;
          case (st_r.cap)
            CAP_EIGHT: st_nxt.cap = CAP_QUART;                   // [R4]
            CAP_QUART: st_nxt.cap = CAP_HALF;                    // [R4]
            default:   st_nxt.cap = CAP_NOM;                     // [R4]
          endcase
        end else if (st_r.cap != CAP_NOM) begin
          st_nxt.ok_run = st_r.ok_run + 3'h1;
        end else begin
          st_nxt.ok_run   = 3'h0;
          st_nxt.oc_total = 8'h0;
        end
      end
      // New cap applies to the duty in the same update that sets it
      st_nxt.duty = (duty_nom_i < cap_value(st_nxt.cap)) ? duty_nom_i : cap_value(st_nxt.cap); // [R6]
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign duty_o   = st_r.duty;
  assign hiccup_o = st_r.hiccup;
  assign cap_o    = st_r.cap;

endmodule // bfl_foldback
`default_nettype wire

// file: src/bfl_light_load.sv
// Light-load controller: entry into and exit from adaptive on-time operation
`timescale 1ns/100ps
`default_nettype none
module bfl_light_load
  import bfl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       cyc_en_i,
  input  wire logic       aot_allow_i,
  input  wire bfl_sense_t sense_i,
  input  wire logic       calib_done_i,
  output logic            aot_o,
  output logic            pulse_o,
  output logic            ls_on_o
);

  typedef struct packed {
    bfl_ll_t    st;
    logic [3:0] zc_run;
    logic [1:0] below_run;
    logic       armed;
  } bfl_ll_st_t;

  bfl_ll_st_t st_r, st_nxt;
  logic       blocked;

  // Blocked by config, tracking or a reference ramp
  assign blocked = !aot_allow_i || sense_i.tracking || sense_i.ref_ramping; // [R13][R20][R21]

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    if (sense_i.ref_ramping) begin
      st_nxt.armed = 1'b0;                                      // Rearm only after new sample [R21]
    end else if (calib_done_i) begin
      st_nxt.armed = 1'b1;
    end
    if (blocked || !st_r.armed) begin
      st_nxt.st     = LL_FORCED_CONTINUOUS_MODE;
      st_nxt.zc_run = 4'h0;
    end else if (st_r.st != LL_FORCED_CONTINUOUS_MODE && sense_i.vsense_below_95) begin
      st_nxt.st     = LL_FORCED_CONTINUOUS_MODE;                                  // [R17]
      st_nxt.zc_run = 4'h0;
    end else begin
      case (st_r.st)
        LL_FORCED_CONTINUOUS_MODE: begin
          if (cyc_en_i) begin
            if (sense_i.zero_cross) begin
              if (st_r.zc_run + 4'h1 == ZC_RUN) begin
                st_nxt.st        = LL_PULSE;                    // [R15]
                st_nxt.below_run = 2'h0;
              end else begin
                st_nxt.zc_run = st_r.zc_run + 4'h1;
              end
            end else begin
              st_nxt.zc_run = 4'h0;
            end
          end
        end
        LL_PULSE: st_nxt.st = LL_DIODE;                         // One fixed-width pulse [R16]
        LL_DIODE: begin
          if (sense_i.zero_cross) begin
            st_nxt.st = LL_IDLE;                                // Low side off at zero [R16]
            if (sense_i.vsense_below_ref) begin
              if (st_r.below_run + 2'h1 == BELOW_RUN) begin
                st_nxt.st     = LL_FORCED_CONTINUOUS_MODE;                        // [R18]
                st_nxt.zc_run = 4'h0;
              end else begin
                st_nxt.below_run = st_r.below_run + 2'h1;
              end
            end else begin
              st_nxt.below_run = 2'h0;
            end
          end
        end
        LL_IDLE: begin
          if (sense_i.vsense_below_ref && !sense_i.current_pos) begin
            st_nxt.st = LL_PULSE;                               // Postponed while current positive [R19]
          end
        end
        default: st_nxt.st = LL_FORCED_CONTINUOUS_MODE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign aot_o   = (st_r.st != LL_FORCED_CONTINUOUS_MODE);
  assign pulse_o = (st_r.st == LL_PULSE);
  assign ls_on_o = (st_r.st == LL_DIODE);

endmodule // bfl_light_load
`default_nettype wire

// file: src/bfl_top.sv
// Top: APB registers, thermal fault handling, feed-forward gate, drive muxing
// Functional notes
// R1: constant-current overload above half caps duty at half
// R2: further three-cycle runs cap quarter, then eighth
// R3: at eighth, switch until count max, then hiccup
// R4: four clear cycles double cap back to nominal
// R5: default eight overcurrents, hiccup twenty milliseconds, retry
// R6: applied duty is min of nominal and cap
// R7: temperature byte reads degrees minus forty
// R8: trip threshold resets to 125, writable
// R9: inhibit response drops enable and both drives
// R10: restart only 25 degrees below threshold
// R11: response ignore, inhibit-restart or latched shutdown
// R12: feed-forward off below 4.7 volts input
// R13: adaptive on-time only when config bit set
// R14: sample error amp after ramp, hold register
// R15: eight zero-crossing cycles enter adaptive on-time
// R16: pulse, low side to zero, then both off
// R17: exit when output at 95 percent reference
// R18: exit after three zero-crosses below reference
// R19: postpone pulse while inductor current positive
// R20: tracking mode forces continuous conduction
// R21: no adaptive mode during ramps until resampled
// R22: software should prefer forced continuous conduction
`timescale 1ns/100ps
`default_nettype none
module bfl_top
  import bfl_pkg::*;
#(
  parameter int HICCUP_LEN = HICCUP_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Switching cycle and loop
  input  wire logic        CYCLE_EN_I,
  input  wire logic [7:0]  DUTY_NOM_I,
  input  wire logic [7:0]  DIE_TEMP_C_I,
  input  wire logic [7:0]  ERR_AMP_CODE_I,
  input  wire bfl_sense_t  SENSE_I,
  // Power stage
  output logic [7:0]       DUTY_O,
  output logic             CONV_EN_O,
  output logic             HIGH_SIDE_DRIVE_O,
  output logic             LOW_SIDE_DRIVE_O,
  output logic             ADAPTIVE_ON_TIME_MODE_O,
  output logic             FEED_FORWARD_EN_O,
  output logic [7:0]       CALIB_DAC_O
);

  // Synchronised comparator inputs and block state
  typedef struct packed {
    bfl_sense_t  sense_m;
    bfl_sense_t  sense;
    logic [7:0]  temp_m;
    logic [7:0]  temp;
    bfl_cfg_t    cfg;
    logic        latch_clr;
    logic [7:0]  ot_limit;
    logic [7:0]  oc_max;
    logic        ot_hot;
    logic        ot_latched;
    logic        ramp_d;
    logic        calib_done;
    logic [7:0]  calib;
    logic [31:0] prdata;
    logic        ff_en;
  } bfl_top_st_t;

  bfl_top_st_t st_r, st_nxt;

  logic [7:0] fb_duty;
  logic       hiccup;
  bfl_cap_t   fb_cap;
  logic       adaptive_on_time_mode;
  logic       aot_pulse;
  logic       aot_ls;
  logic       apb_wr;
  logic       apb_rd;
  logic       ot_block;
  logic [8:0] restart_lvl;

  // APB writes in the access phase, reads in the setup phase; no wait states
  assign apb_wr    = PSEL_I && PENABLE_I && PWRITE_I;
  assign apb_rd    = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign PRDATA_O  = st_r.prdata;

  // Thermal block applies for inhibit while hot and for latched shutdown
  assign ot_block    = (st_r.cfg.otr == OTR_INHIBIT && st_r.ot_hot) ||
                       (st_r.cfg.otr == OTR_LATCH && st_r.ot_latched); // [R9][R11]
  assign restart_lvl = {1'b0, st_r.ot_limit} - {1'b0, OT_HYST};

  // Register file, thermal state and sampling
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sense_m = SENSE_I;
    st_nxt.sense   = st_r.sense_m;
    st_nxt.temp_m  = DIE_TEMP_C_I;
    st_nxt.temp    = st_r.temp_m;
    st_nxt.ramp_d  = st_r.sense.ref_ramping;
    st_nxt.ff_en   = st_r.sense.power_input_voltage_above_4v7;                       // [R12]
    st_nxt.latch_clr = 1'b0;

    // Sample the error amp code once the ramp finishes
    st_nxt.calib_done = 1'b0;
    if (st_r.ramp_d && !st_r.sense.ref_ramping) begin
      st_nxt.calib      = ERR_AMP_CODE_I;                             // [R14]
      st_nxt.calib_done = 1'b1;                                       // [R21]
    end

    // Trip above threshold, clear only below threshold minus hysteresis
    if (st_r.temp > st_r.ot_limit) begin
      st_nxt.ot_hot = 1'b1;                                           // [R8]
    end else if ({1'b0, st_r.temp} < restart_lvl) begin
      st_nxt.ot_hot = 1'b0;                                           // [R10]
    end
    if (st_r.latch_clr) begin
      st_nxt.ot_latched = 1'b0;
    end
    if (st_r.temp > st_r.ot_limit && st_r.cfg.otr == OTR_LATCH) begin
      st_nxt.ot_latched = 1'b1;                                       // Set wins over clear [R11]
    end

    // Register writes
    if (apb_wr) begin
      case (PADDR_I)
        ADDR_CTRL: begin
          st_nxt.cfg.cc_mode    = PWDATA_I[CTRL_CC_BIT];
          st_nxt.cfg.aot_enable = PWDATA_I[CTRL_AOT_BIT];             // [R13]
          st_nxt.cfg.otr        = bfl_otr_t'(PWDATA_I[CTRL_OTR_LSB +: 2]); // [R11]
          st_nxt.latch_clr      = PWDATA_I[CTRL_LATCH_CLR_BIT];
        end
        ADDR_OT_LIMIT: st_nxt.ot_limit = PWDATA_I[7:0];               // [R8]
        ADDR_OC_MAX:   st_nxt.oc_max   = PWDATA_I[7:0];
        default: ;
      endcase
    end

    // Register reads, captured in the setup cycle
    if (apb_rd) begin
      case (PADDR_I)
        ADDR_CTRL:     st_nxt.prdata = {28'h0, st_r.cfg.otr, st_r.cfg.aot_enable, st_r.cfg.cc_mode};
        ADDR_OT_LIMIT: st_nxt.prdata = {24'h0, st_r.ot_limit};
        ADDR_OC_MAX:   st_nxt.prdata = {24'h0, st_r.oc_max};
        ADDR_TEMP:     st_nxt.prdata = {24'h0, st_r.temp - TEMP_OFFSET}; // [R7]
        ADDR_STATUS:   st_nxt.prdata = {25'h0, st_r.ff_en, adaptive_on_time_mode, fb_cap, hiccup, st_r.ot_latched, st_r.ot_hot};
        ADDR_CALIB:    st_nxt.prdata = {24'h0, st_r.calib};
        default:       st_nxt.prdata = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      st_r            <= '0;
      st_r.cfg.cc_mode    <= CTRL_RST[CTRL_CC_BIT];
      st_r.cfg.aot_enable <= CTRL_RST[CTRL_AOT_BIT];
      st_r.cfg.otr        <= bfl_otr_t'(CTRL_RST[CTRL_OTR_LSB +: 2]); // [R11]
      st_r.ot_limit   <= OT_LIMIT_RST;
      st_r.oc_max     <= OC_MAX_RST;
      st_r.sense.ref_ramping   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Overcurrent foldback and hiccup
  bfl_foldback #(
    .HICCUP_LEN (HICCUP_LEN)
  ) u_foldback (
    .clk_i      (CLK_I),
    .reset_n_i  (RESET_N_I),
    .cyc_en_i   (CYCLE_EN_I),
    .oc_i       (st_r.sense.overcurrent_trip),
    .cc_mode_i  (st_r.cfg.cc_mode),
    .oc_max_i   (st_r.oc_max),
    .duty_nom_i (DUTY_NOM_I),
    .duty_o     (fb_duty),
    .hiccup_o   (hiccup),
    .cap_o      (fb_cap)
  );

  // Light-load mode control
  bfl_light_load u_light_load (
    .clk_i        (CLK_I),
    .reset_n_i    (RESET_N_I),
    .cyc_en_i     (CYCLE_EN_I),
    .aot_allow_i  (st_r.cfg.aot_enable),
    .sense_i      (st_r.sense),
    .calib_done_i (st_r.calib_done),
    .aot_o        (adaptive_on_time_mode),
    .pulse_o      (aot_pulse),
    .ls_on_o      (aot_ls)
  );

  // Conversion enable and drive muxing
  assign CONV_EN_O               = !hiccup && !ot_block;              // [R5][R9]
  assign DUTY_O                  = CONV_EN_O ? fb_duty : 8'h00;
  assign HIGH_SIDE_DRIVE_O       = CONV_EN_O && (adaptive_on_time_mode ? aot_pulse : (fb_duty != 8'h00)); // [R9][R16]
  assign LOW_SIDE_DRIVE_O        = CONV_EN_O && (adaptive_on_time_mode ? aot_ls : 1'b1);               // [R9][R16]
  assign ADAPTIVE_ON_TIME_MODE_O = adaptive_on_time_mode;
  assign FEED_FORWARD_EN_O       = st_r.ff_en;                        // [R12]
  assign CALIB_DAC_O             = st_r.calib;                        // [R14]

endmodule // bfl_top
`default_nettype wire

// file: bench/bfl_sva.sv
// Checker: port-level properties of the buck fault and light-load block
`timescale 1ns/100ps
`default_nettype none
module bfl_sva
  import bfl_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        CYCLE_EN_I,
  input wire logic [7:0]  DUTY_NOM_I,
  input wire logic [7:0]  DIE_TEMP_C_I,
  input wire bfl_sense_t  SENSE_I,
  input wire logic [7:0]  DUTY_O,
  input wire logic        CONV_EN_O,
  input wire logic        HIGH_SIDE_DRIVE_O,
  input wire logic        LOW_SIDE_DRIVE_O,
  input wire logic        ADAPTIVE_ON_TIME_MODE_O,
  input wire logic        FEED_FORWARD_EN_O,
  input wire logic [7:0]  CALIB_DAC_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Saturating run lengths of held comparator levels
  logic [4:0] trk_n_r, b95_n_r, low_n_r;
  always_ff @(posedge CLK_I) begin
    trk_n_r <= (!RESET_N_I || !SENSE_I.tracking) ? 5'h0 : trk_n_r + 5'(trk_n_r != 5'h1f);
    b95_n_r <= (!RESET_N_I || !SENSE_I.vsense_below_95) ? 5'h0 : b95_n_r + 5'(b95_n_r != 5'h1f);
    low_n_r <= (!RESET_N_I || SENSE_I.power_input_voltage_above_4v7) ? 5'h0 : low_n_r + 5'(low_n_r != 5'h1f);
  end
  // Temperature read: settled input, setup then access
  sequence s_rd_setup;
    PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == ADDR_TEMP && $past(DIE_TEMP_C_I, 4) == DIE_TEMP_C_I;
  endsequence
  sequence s_rd_access;
    PSEL_I && PENABLE_I && $stable(DIE_TEMP_C_I);
  endsequence
  property p_temp;
    s_rd_setup ##1 s_rd_access |-> PRDATA_O == {24'h0, DIE_TEMP_C_I - TEMP_OFFSET};
  endproperty
  a_temp: assert property (p_temp) else $error("temperature byte wrong");
  property p_apb;
    PSEL_I && PENABLE_I |-> PREADY_O && !PSLVERR_O;
  endproperty
  a_apb: assert property (p_apb) else $error("access not answered");
  property p_off;
    !CONV_EN_O |-> !HIGH_SIDE_DRIVE_O && !LOW_SIDE_DRIVE_O;
  endproperty
  a_off: assert property (p_off) else $error("drive while disabled");
  property p_ff;
    low_n_r >= 5'h14 |-> !FEED_FORWARD_EN_O;
  endproperty
  a_ff: assert property (p_ff) else $error("feed-forward on at low input");
  property p_trk;
    trk_n_r >= 5'h14 |-> !ADAPTIVE_ON_TIME_MODE_O;
  endproperty
  a_trk: assert property (p_trk) else $error("light-load mode while tracking");
  property p_b95;
    b95_n_r >= 5'h8 |-> !ADAPTIVE_ON_TIME_MODE_O;
  endproperty
  a_b95: assert property (p_b95) else $error("light-load mode kept at low output");
  property p_dac;
    SENSE_I.ref_ramping [*4] |=> $stable(CALIB_DAC_O);
  endproperty
  a_dac: assert property (p_dac) else $error("sample moved during ramp");
  property p_duty;
    CYCLE_EN_I |=> DUTY_O <= $past(DUTY_NOM_I);
  endproperty
  a_duty: assert property (p_duty) else $error("duty above nominal");
endmodule // bfl_sva
bind bfl_top bfl_sva u_sva (.CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O,
  .PREADY_O, .PSLVERR_O, .CYCLE_EN_I, .DUTY_NOM_I, .DIE_TEMP_C_I, .SENSE_I, .DUTY_O, .CONV_EN_O, .HIGH_SIDE_DRIVE_O,
  .LOW_SIDE_DRIVE_O, .ADAPTIVE_ON_TIME_MODE_O, .FEED_FORWARD_EN_O, .CALIB_DAC_O);
`default_nettype wire

// file: bench/bfl_stage_model.sv
// Power-stage model: cycle strobe and comparator levels settled once per cycle
`timescale 1ns/100ps
`default_nettype none
module bfl_stage_model
  import bfl_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    reset_n_i,
  input  wire logic    oc_i,
  input  wire logic    light_i,
  input  wire logic    power_input_voltage_ok_i,
  input  wire logic    low_out_i,
  input  wire logic    below_ref_i,
  input  wire logic    ramp_i,
  input  wire logic    track_i,
  input  wire logic    ls_drive_i,
  output var logic     cycle_en_o,
  output var bfl_sense_t sense_o
);
  logic [2:0] phase_r = 3'h0;
  initial begin
    cycle_en_o = 1'b0;
    sense_o = '0;
  end
  // Eight clocks per cycle; levels move only at the strobe, or while in reset
  always @(posedge clk_i) begin
    phase_r <= reset_n_i ? phase_r + 3'h1 : 3'h0;
    cycle_en_o <= (phase_r == 3'h7);
    if (phase_r == 3'h7 || !reset_n_i) begin
      sense_o <= {oc_i, light_i, ls_drive_i, low_out_i | below_ref_i, low_out_i, power_input_voltage_ok_i, ramp_i, track_i};
    end
  end
endmodule // bfl_stage_model
`default_nettype wire

// file: bench/tb_top.sv
// Testbench: registers, foldback, hiccup, thermal and light-load scenarios
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import bfl_pkg::*;
;
  localparam int HLEN = 50;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00, nom = 8'hf0, temp = 8'h3c, code = 8'h00, seed = 8'h61;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        oc = 1'b0, light = 1'b0, power_input_voltage = 1'b1, b95 = 1'b0, ramp = 1'b1, trk = 1'b0, bref = 1'b0;
  logic        pready, pslverr, cyc, conv, hs, ls, adaptive_on_time_mode, ff;
  logic [7:0]  duty, dac;
  bfl_sense_t  sense;
  int          errors = 0, n_checks = 0, n;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  logic [31:0] t_ctrl[7] = '{32'h5, 32'h5, 32'h5, 32'h1, 32'h9, 32'h9, 32'h19};
  logic [7:0]  t_temp[7] = '{8'h82, 8'h6e, 8'h63, 8'h82, 8'h82, 8'h1e, 8'h1e};
  logic [31:0] t_conv[7] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0, 32'h1};
  // Clock, 4 ns period
  always #2 clk = ~clk;
  bfl_top #(.HICCUP_LEN(HLEN)) DUT (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CYCLE_EN_I(cyc), .DUTY_NOM_I(nom), .DIE_TEMP_C_I(temp), .ERR_AMP_CODE_I(code),
    .SENSE_I(sense), .DUTY_O(duty), .CONV_EN_O(conv), .HIGH_SIDE_DRIVE_O(hs), .LOW_SIDE_DRIVE_O(ls),
    .ADAPTIVE_ON_TIME_MODE_O(adaptive_on_time_mode), .FEED_FORWARD_EN_O(ff), .CALIB_DAC_O(dac));
  bfl_stage_model u_stage (.clk_i(clk), .reset_n_i(rst_n), .oc_i(oc), .light_i(light), .power_input_voltage_ok_i(power_input_voltage),
    .low_out_i(b95), .below_ref_i(bref), .ramp_i(ramp), .track_i(trk), .ls_drive_i(ls), .cycle_en_o(cyc),
    .sense_o(sense));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // One APB transfer; for a read, d is the expected word
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input string nm);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) begin
      exp_q.push_back(d);
      nm_q.push_back(nm);
    end
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Wait k switching cycles, then two clocks for outputs to settle
  task automatic pulses(input int k);
    repeat (k) @(posedge clk iff cyc);
    repeat (2) @(posedge clk);
  endtask
  // Read data is compared at the edge that completes the access
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready === 1'b1 && exp_q.size() > 0)
      check(nm_q.pop_front(), prdata, exp_q.pop_front());
  end
  initial begin
    #40000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h5, "ctrl");
    apb(1'b0, ADDR_OT_LIMIT, 32'h7d, "ot_limit");
    apb(1'b0, ADDR_OC_MAX, 32'h8, "oc_max");
    apb(1'b0, 8'h18, 32'h0, "unmapped");
    apb(1'b1, ADDR_OT_LIMIT, 32'h50, "");
    apb(1'b0, ADDR_OT_LIMIT, 32'h50, "ot_limit_wr");
    apb(1'b1, ADDR_OT_LIMIT, 32'h7d, "");
    apb(1'b1, ADDR_TEMP, 32'hff, "");
    check("ff_on", 32'(ff), 32'h1);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      temp <= 8'h28 + seed % 8'h50;
      code <= seed;
      pulses(2);
      apb(1'b0, ADDR_TEMP, {24'h0, seed % 8'h50}, "temp_byte");
    end
    ramp <= 1'b0;
    pulses(3);
    check("calib_dac", 32'(dac), 32'(code));
    apb(1'b0, ADDR_CALIB, 32'(code), "calib");
    power_input_voltage <= 1'b0;
    pulses(3);
    check("ff_off", 32'(ff), 32'h0);
    power_input_voltage <= 1'b1;
    // Foldback down and back up
    apb(1'b1, ADDR_OC_MAX, 32'h14, "");
    oc <= 1'b1;
    pulses(3);
    check("duty_two_oc", 32'(duty), 32'hf0);
    pulses(1);
    check("duty_half", 32'(duty), 32'h80);
    nom <= 8'h60;
    pulses(1);
    check("duty_low_nominal", 32'(duty), 32'h60);
    nom <= 8'hf0;
    pulses(2);
    check("duty_quarter", 32'(duty), 32'h40);
    pulses(3);
    check("duty_eighth", 32'(duty), 32'h20);
    apb(1'b0, ADDR_STATUS, 32'h50, "status_eighth");
    pulses(3);
    check("eighth_running", 32'({duty, conv}), 32'h41);
    oc <= 1'b0;
    pulses(5);
    check("duty_up_quarter", 32'(duty), 32'h40);
    pulses(4);
    check("duty_up_half", 32'(duty), 32'h80);
    pulses(4);
    check("duty_up_nominal", 32'(duty), 32'hf0);
    // Hiccup after the default count
    apb(1'b1, ADDR_OC_MAX, 32'h8, "");
    oc <= 1'b1;
    pulses(8);
    check("conv_before_hiccup", 32'(conv), 32'h1);
    n = 0;
    while (conv !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    oc <= 1'b0;
    n = 0;
    while (conv === 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("hiccup_len", 32'(n), 32'(HLEN));
    // Thermal responses: inhibit, hysteresis, ignore, latch and clear
    foreach (t_ctrl[i]) begin
      apb(1'b1, ADDR_CTRL, t_ctrl[i], "");
      temp <= t_temp[i];
      pulses(3);
      check("conv_thermal", 32'(conv), t_conv[i]);
      check("drives_thermal", 32'({hs, ls}), t_conv[i] * 32'h3);
    end
    // Light-load entry and exit, enabled only for this scenario
    apb(1'b1, ADDR_CTRL, 32'h5, "");
    light <= 1'b1;
    pulses(10);
    check("aot_disabled", 32'(adaptive_on_time_mode), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h7, "");
    trk <= 1'b1;
    pulses(10);
    check("aot_tracking", 32'(adaptive_on_time_mode), 32'h0);
    trk <= 1'b0;
    pulses(10);
    check("aot_entered", 32'(adaptive_on_time_mode), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h60, "status_aot");
    bref <= 1'b1;
    pulses(4);
    check("aot_below_ref", 32'(adaptive_on_time_mode), 32'h0);
    bref <= 1'b0;
    pulses(10);
    check("aot_reentered", 32'(adaptive_on_time_mode), 32'h1);
    light <= 1'b0;
    b95 <= 1'b1;
    pulses(3);
    check("aot_exit", 32'(adaptive_on_time_mode), 32'h0);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
